// ### rtl/isftc_pkg.sv
// Purpose: shared constants of the image sensor frame timing controller
// Assumes: 8-bit register map reached over the two-wire serial slave
// Notes: only the low 32 register addresses are implemented
package isftc_pkg;
    // ==========================================================
    // serial bus addressing
    localparam logic [7:0] DEV_WR_ADDR = 8'h42; // write address byte
    localparam logic [7:0] DEV_RD_ADDR = 8'h43; // read address byte
    localparam int REG_COUNT = 32; // implemented register slots
    localparam logic [2:0] MAP_HIGH_ZERO = 3'h0; // address[7:5] inside the map
    // ==========================================================
    // register offsets
    localparam logic [4:0] A_ID = 5'h00; // read-only identity
    localparam logic [4:0] A_HB_LO = 5'h01; // hblank_low_byte
    localparam logic [4:0] A_VB_LO = 5'h02; // vblank_low_byte
    localparam logic [4:0] A_EXP_HI = 5'h03; // exposure [11:8] in [3:0]
    localparam logic [4:0] A_EXP_LO = 5'h04; // exposure [7:0]
    localparam logic [4:0] A_HT_HI = 5'h09; // crop_height_high
    localparam logic [4:0] A_HT_LO = 5'h0a; // crop_height_low
    localparam logic [4:0] A_WD_HI = 5'h0b; // crop_width_high
    localparam logic [4:0] A_WD_LO = 5'h0c; // crop_width_low
    localparam logic [4:0] A_LEAD = 5'h0d; // frame_lead_rows
    localparam logic [4:0] A_TRAIL = 5'h0e; // frame_trail_rows
    localparam logic [4:0] A_BLK_HI = 5'h0f; // blanking_high_nibbles
    localparam logic [4:0] A_HOLD = 5'h12; // hold_delay_pixels
    localparam logic [4:0] A_MODE = 5'h14; // readout mode, flips
    // ==========================================================
    // field positions
    localparam int MODE_COL_FLIP = 0; // mirror columns
    localparam int MODE_ROW_FLIP = 1; // upside down rows
    // ==========================================================
    // reset values
    localparam logic [7:0] R_HB_LO = 8'h6a;
    localparam logic [7:0] R_VB_LO = 8'h70;
    localparam logic [7:0] R_EXP_LO = 8'h96;
    localparam logic [7:0] R_HT_HI = 8'h01;
    localparam logic [7:0] R_HT_LO = 8'he8;
    localparam logic [7:0] R_WD_HI = 8'h02;
    localparam logic [7:0] R_WD_LO = 8'h88;
    localparam logic [7:0] R_LEAD = 8'h02;
    localparam logic [7:0] R_TRAIL = 8'h04;
    localparam logic [7:0] R_HOLD = 8'h42;
    // ==========================================================
    // timing terms, in rows or pixel clocks
    localparam logic [13:0] FRAME_EXTRA_ROWS = 14'h0008; // window minus valid lines
    localparam logic [13:0] LINE_EXTRA_PIX = 14'h0004; // fixed tail of a row
    localparam logic [13:0] EDGE_ROWS = 14'h0004; // dummy rows each window edge
    // ==========================================================
    // serial slave states
    typedef enum {S_IDLE, S_DEV, S_REG, S_WR, S_ACK, S_RD, S_MACK} isftc_bus_e;

    // reset value of one register slot
    function automatic logic [7:0] reg_reset(input logic [4:0] a);
        case (a)
            A_HB_LO: reg_reset = R_HB_LO;
            A_VB_LO: reg_reset = R_VB_LO;
            A_EXP_LO: reg_reset = R_EXP_LO;
            A_HT_HI: reg_reset = R_HT_HI;
            A_HT_LO: reg_reset = R_HT_LO;
            A_WD_HI: reg_reset = R_WD_HI;
            A_WD_LO: reg_reset = R_WD_LO;
            A_LEAD: reg_reset = R_LEAD;
            A_TRAIL: reg_reset = R_TRAIL;
            A_HOLD: reg_reset = R_HOLD;
            default: reg_reset = 8'h00;
        endcase
    endfunction
endpackage

// ### rtl/isftc_top.sv
// Purpose: serial register slave and frame/line timing generator of the sensor
// Assumes: serial pins are asynchronous and sampled by i_mclk; one pixel per i_mclk
// Notes: pixel clock equals i_mclk; timing follows register changes at once
// Behaviour
// RQ1: answer address bytes 0x42 write, 0x43 read
// RQ2: host makes start and stop conditions
// RQ3: host drives the serial clock always
// RQ4: single write: three bytes each acknowledged
// RQ5: incremental write acknowledges every data byte
// RQ6: single read returns one byte, host nacks
// RQ7: incremental read returns consecutive bytes
// RQ8: pointer advances after each data byte
// RQ9: columns ascend, or descend when flipped
// RQ10: rows ascend, or descend when flipped
// RQ11: colour lines alternate blue/green and green/red
// RQ12: frame rows equal blanking plus valid plus eight
// RQ13: vertical blanking from 0x0f[7:4] and 0x02
// RQ14: lead rows taken from register 0x0d
// RQ15: trail rows taken from register 0x0e
// RQ16: frame sync inactive during idle rows
// RQ17: valid lines equal window height minus eight
// RQ18: short exposure: idle is blanking minus lead, trail
// RQ19: long exposure stretches idle rows
// RQ20: row time is blank+hold+width+4 clocks
// RQ21: horizontal blanking from 0x0f[3:0] and 0x01
// RQ22: hold delay taken from register 0x12
// RQ23: host programs window width 648 for VGA
`timescale 1ns/1ps
`default_nettype none
module isftc_top #(
    parameter logic [7:0] CHIP_ID = 8'h5a // arbitrary identity value
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_serial_clock_pin,
    input wire logic i_serial_line_pin,
    output logic o_serial_line_pin,
    output logic o_serial_line_oe,
    output logic o_frame_sync,
    output logic o_line_valid,
    output logic [9:0] o_col_addr,
    output logic [8:0] o_row_addr,
    output logic o_cfa_red_line
);
    // ==========================================================
    // state of the whole block
    typedef struct packed {
        logic scl_s1; // first sync stage, read only by scl_s2
        logic scl_s2;
        logic scl_q; // delayed copy for edge finding
        logic sda_s1;
        logic sda_s2;
        logic sda_q;
        isftc_pkg::isftc_bus_e st; // serial slave state
        isftc_pkg::isftc_bus_e after_ack; // state following an ack slot
        logic ack_drive; // ack slot already driven
        logic [3:0] bitcnt; // bits of current byte
        logic [7:0] shreg; // shift register
        logic [7:0] ptr; // register pointer
        logic sda_oe; // pull line low
        logic [isftc_pkg::REG_COUNT-1:0][7:0] regs; // register file
        logic [13:0] col; // pixel counter inside a row
        logic [13:0] row; // row counter inside a frame
        logic frame_sync;
        logic line_valid;
        logic [9:0] col_addr;
        logic [8:0] row_addr;
        logic cfa_red;
    } isftc_state_s;

    isftc_state_s q; // registered state
    isftc_state_s next_q; // next state

    // ==========================================================
    // helpers
    // subtraction clamped at zero, guards bad lead/trail settings
    function automatic logic [13:0] sub_sat(input logic [13:0] a, input logic [13:0] b);
        sub_sat = (a > b) ? a - b : 14'h0000;
    endfunction

    // read data for an address byte; outside the map reads zero
    function automatic logic [7:0] reg_read(input isftc_state_s s, input logic [7:0] a);
        if (a[7:5] != isftc_pkg::MAP_HIGH_ZERO) begin
            reg_read = 8'h00;
        end else if (a[4:0] == isftc_pkg::A_ID) begin
            reg_read = CHIP_ID;
        end else begin
            reg_read = s.regs[a[4:0]];
        end
    endfunction

    // ==========================================================
    // decoded timing terms
    logic scl_rise; // serial clock rising edge
    logic scl_fall; // serial clock falling edge
    logic bus_start; // start or repeated start
    logic bus_stop; // stop condition
    logic [7:0] byte_in; // byte including the bit just sampled
    logic [13:0] hblank; // horizontal_blank_pixels
    logic [13:0] vblank; // vertical_blank_rows
    logic [13:0] win_h; // window height
    logic [13:0] win_w; // window width
    logic [13:0] expo; // exposure in rows
    logic [13:0] lead_rows; // frame_lead_rows
    logic [13:0] trail_rows; // frame_trail_rows
    logic [13:0] hold_pix; // hold_delay_pixels
    logic [13:0] idle_rows; // frame_sync_idle_rows
    logic [13:0] row_time; // pixel clocks per row
    logic [13:0] frame_period; // rows per frame
    logic [13:0] win_row; // row index inside window
    logic [13:0] win_col; // column index inside window
    logic in_win_row;
    logic in_win_col;

    // edges come from the second and third stages only
    assign scl_rise = q.scl_s2 & ~q.scl_q;
    assign scl_fall = ~q.scl_s2 & q.scl_q;
    assign bus_start = q.scl_s2 & q.scl_q & q.sda_q & ~q.sda_s2; // see RQ2
    assign bus_stop = q.scl_s2 & q.scl_q & ~q.sda_q & q.sda_s2; // see RQ2
    assign byte_in = {q.shreg[6:0], q.sda_s2};

    // register fields widened to the counter width
    assign hblank = {2'b00, q.regs[isftc_pkg::A_BLK_HI][3:0],
                     q.regs[isftc_pkg::A_HB_LO]}; // see RQ21
    assign vblank = {2'b00, q.regs[isftc_pkg::A_BLK_HI][7:4],
                     q.regs[isftc_pkg::A_VB_LO]}; // see RQ13
    assign win_h = {5'h00, q.regs[isftc_pkg::A_HT_HI][0], q.regs[isftc_pkg::A_HT_LO]};
    assign win_w = {4'h0, q.regs[isftc_pkg::A_WD_HI][1:0], q.regs[isftc_pkg::A_WD_LO]};
    assign expo = {2'b00, q.regs[isftc_pkg::A_EXP_HI][3:0], q.regs[isftc_pkg::A_EXP_LO]};
    assign lead_rows = {6'h00, q.regs[isftc_pkg::A_LEAD]}; // see RQ14
    assign trail_rows = {6'h00, q.regs[isftc_pkg::A_TRAIL]}; // see RQ15
    assign hold_pix = {6'h00, q.regs[isftc_pkg::A_HOLD]}; // see RQ22

    // idle rows: blanking rules unless exposure is longer than the frame
    always_comb begin
        if (expo > win_h + vblank) begin
            idle_rows = sub_sat(expo, win_h + lead_rows + trail_rows); // see RQ19
        end else begin
            idle_rows = sub_sat(vblank, lead_rows + trail_rows); // see RQ18
        end
    end

    // row and frame lengths; window holds valid lines plus eight
    assign row_time = hblank + hold_pix + win_w + isftc_pkg::LINE_EXTRA_PIX; // see RQ20
    assign frame_period = idle_rows + lead_rows + win_h + trail_rows; // see RQ12

    // window position of the current counters
    assign win_row = q.row - idle_rows - lead_rows;
    assign win_col = q.col - hblank - hold_pix;
    assign in_win_row = (q.row >= idle_rows + lead_rows) &&
                        (q.row < idle_rows + lead_rows + win_h);
    assign in_win_col = (q.col >= hblank + hold_pix) &&
                        (q.col < hblank + hold_pix + win_w);

    // ==========================================================
    // next state
    always_comb begin
        next_q = q;
        // two flip-flops before any logic looks at the pins
        next_q.scl_s1 = i_serial_clock_pin;
        next_q.scl_s2 = q.scl_s1;
        next_q.scl_q = q.scl_s2;
        next_q.sda_s1 = i_serial_line_pin;
        next_q.sda_s2 = q.sda_s1;
        next_q.sda_q = q.sda_s2;

        // ------------------------------------------------------
        // serial slave; sample on rising, drive on falling edge
        if (bus_stop) begin
            // stop frees the line; the pointer survives
            next_q.st = isftc_pkg::S_IDLE;
            next_q.sda_oe = 1'b0;
        end else if (bus_start) begin
            // repeated start keeps the pointer for reads
            next_q.st = isftc_pkg::S_DEV;
            next_q.bitcnt = 4'h0;
            next_q.sda_oe = 1'b0;
            next_q.ack_drive = 1'b0;
        end else begin
            case (q.st)
                isftc_pkg::S_DEV, isftc_pkg::S_REG, isftc_pkg::S_WR: begin
                    if (scl_rise) begin
                        next_q.shreg = byte_in;
                        next_q.bitcnt = q.bitcnt + 4'h1;
                        if (q.bitcnt == 4'h7) begin
                            next_q.bitcnt = 4'h0;
                            next_q.st = isftc_pkg::S_ACK;
                            next_q.ack_drive = 1'b0;
                            if (q.st == isftc_pkg::S_DEV) begin
                                // other addresses are ignored until next start
                                if (byte_in == isftc_pkg::DEV_WR_ADDR) begin
                                    next_q.after_ack = isftc_pkg::S_REG; // see RQ1
                                end else if (byte_in == isftc_pkg::DEV_RD_ADDR) begin
                                    next_q.after_ack = isftc_pkg::S_RD; // see RQ1
                                end else begin
                                    next_q.st = isftc_pkg::S_IDLE;
                                end
                            end else if (q.st == isftc_pkg::S_REG) begin
                                next_q.ptr = byte_in; // see RQ4
                                next_q.after_ack = isftc_pkg::S_WR;
                            end else begin
                                // identity slot and unmapped space drop writes
                                if (q.ptr[7:5] == isftc_pkg::MAP_HIGH_ZERO &&
                                    q.ptr[4:0] != isftc_pkg::A_ID) begin
                                    next_q.regs[q.ptr[4:0]] = byte_in; // see RQ4
                                end
                                next_q.ptr = q.ptr + 8'h01; // see RQ8
                                next_q.after_ack = isftc_pkg::S_WR; // see RQ5
                            end
                        end
                    end
                end
                isftc_pkg::S_ACK: begin
                    if (scl_fall) begin
                        if (!q.ack_drive) begin
                            // pull low across the ninth clock
                            next_q.sda_oe = 1'b1; // see RQ4
                            next_q.ack_drive = 1'b1;
                        end else if (q.after_ack == isftc_pkg::S_RD) begin
                            // first read bit goes out as the ack clock falls, after the ack
                            next_q.shreg = reg_read(q, q.ptr); // see RQ6
                            next_q.sda_oe = ~next_q.shreg[7];
                            next_q.st = isftc_pkg::S_RD;
                        end else begin
                            next_q.sda_oe = 1'b0;
                            next_q.st = q.after_ack;
                        end
                    end
                end
                isftc_pkg::S_RD: begin
                    if (scl_rise) begin
                        next_q.bitcnt = q.bitcnt + 4'h1;
                        if (q.bitcnt == 4'h7) begin
                            next_q.bitcnt = 4'h0;
                            next_q.ptr = q.ptr + 8'h01; // see RQ8
                            next_q.st = isftc_pkg::S_MACK;
                            next_q.ack_drive = 1'b0;
                        end
                    end else if (scl_fall) begin
                        next_q.shreg = {q.shreg[6:0], 1'b0};
                        next_q.sda_oe = ~q.shreg[6];
                    end
                end
                isftc_pkg::S_MACK: begin
                    if (scl_fall && !q.ack_drive) begin
                        // free the line for the host's answer
                        next_q.sda_oe = 1'b0;
                    end else if (scl_fall) begin
                        // host acked: send the following byte
                        next_q.shreg = reg_read(q, q.ptr); // see RQ7
                        next_q.sda_oe = ~next_q.shreg[7];
                        next_q.st = isftc_pkg::S_RD;
                    end else if (scl_rise) begin
                        if (q.sda_s2) begin
                            // no ack ends the read; wait for stop
                            next_q.st = isftc_pkg::S_IDLE; // see RQ6
                        end else begin
                            next_q.ack_drive = 1'b1; // see RQ7
                        end
                    end
                end
                default: begin
                    next_q.sda_oe = 1'b0;
                end
            endcase
        end

        // ------------------------------------------------------
        // pixel and row counters; >= recovers if a shorter setting lands
        if (q.col + 14'h0001 >= row_time) begin
            next_q.col = 14'h0000;
            if (q.row + 14'h0001 >= frame_period) begin
                next_q.row = 14'h0000;
            end else begin
                next_q.row = q.row + 14'h0001;
            end
        end else begin
            next_q.col = q.col + 14'h0001;
        end

        // ------------------------------------------------------
        // registered timing outputs
        next_q.frame_sync = (q.row >= idle_rows); // see RQ16
        next_q.line_valid = in_win_row && in_win_col &&
                            (win_row >= isftc_pkg::EDGE_ROWS) &&
                            (win_row + isftc_pkg::EDGE_ROWS < win_h); // see RQ17
        if (in_win_col) begin
            if (q.regs[isftc_pkg::A_MODE][isftc_pkg::MODE_COL_FLIP]) begin
                next_q.col_addr = 10'(win_w - 14'h0001 - win_col); // see RQ9
            end else begin
                next_q.col_addr = win_col[9:0]; // see RQ9
            end
        end
        if (in_win_row) begin
            if (q.regs[isftc_pkg::A_MODE][isftc_pkg::MODE_ROW_FLIP]) begin
                next_q.row_addr = 9'(win_h - 14'h0001 - win_row); // see RQ10
                next_q.cfa_red = ~win_row[0] ^ win_h[0]; // see RQ11
            end else begin
                next_q.row_addr = win_row[8:0]; // see RQ10
                next_q.cfa_red = win_row[0]; // see RQ11
            end
        end

        // ------------------------------------------------------
        // synchronous reset
        if (!i_nrst) begin
            next_q = '0;
            next_q.st = isftc_pkg::S_IDLE;
            next_q.after_ack = isftc_pkg::S_IDLE;
            next_q.scl_s1 = 1'b1;
            next_q.scl_s2 = 1'b1;
            next_q.scl_q = 1'b1;
            next_q.sda_s1 = 1'b1;
            next_q.sda_s2 = 1'b1;
            next_q.sda_q = 1'b1;
            for (int i = 0; i < isftc_pkg::REG_COUNT; i++) begin
                next_q.regs[i] = isftc_pkg::reg_reset(5'(i));
            end
        end
    end

    // ==========================================================
    // single state register
    always_ff @(posedge i_mclk) begin
        q <= next_q;
    end

    // ==========================================================
    // outputs; open drain data line only ever drives low
    assign o_serial_line_pin = 1'b0;
    assign o_serial_line_oe = q.sda_oe;
    assign o_frame_sync = q.frame_sync;
    assign o_line_valid = q.line_valid;
    assign o_col_addr = q.col_addr;
    assign o_row_addr = q.row_addr;
    assign o_cfa_red_line = q.cfa_red;
endmodule
`default_nettype wire

// ### tb/isftc_host.sv
// Purpose: two-wire bus master model for the serial pins
// Assumes: i_sda is the pulled-up data wire level
// Notes: 80 ns bus clock; pins change on falling i_mclk edges
`timescale 1ns/1ps
`default_nettype none
module isftc_host (
    input wire logic i_mclk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    // ==========
    // idle bus: clock high, data released
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // quarter bus periods, off the sampling edge
    task automatic q(input int n);
        repeat (4 * n) @(negedge i_mclk);
    endtask
    // start, or repeated start from clock low
    task automatic start();
        o_sda_low = 1'b0;
        q(1);
        o_scl = 1'b1;
        q(1);
        o_sda_low = 1'b1;
        q(1);
        o_scl = 1'b0;
        q(1);
    endtask
    // one bit: data moves while clock low, sampled mid-high
    task automatic bit_cycle(input logic b, output logic seen);
        o_sda_low = ~b;
        q(1);
        o_scl = 1'b1;
        q(1);
        seen = i_sda;
        q(1);
        o_scl = 1'b0;
        q(1);
    endtask
    task automatic stop();
        o_sda_low = 1'b1;
        q(1);
        o_scl = 1'b1;
        q(1);
        o_sda_low = 1'b0;
        q(2);
    endtask
    // byte out, msb first; ninth bit left for the ack
    task automatic send(input logic [7:0] d, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(d[i], s);
        bit_cycle(1'b1, s);
        acked = ~s;
    endtask
    // byte in; ack asks for more, nack ends
    task automatic recv(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            d[i] = s;
        end
        bit_cycle(~ack, s);
    endtask
endmodule
`default_nettype wire

// ### tb/isftc_top_asserts.sv
// Purpose: port checks of serial slave and frame timing
// Assumes: one clock, synchronous active-low reset
// Notes: colour check skips rows a mid-frame flip breaks
`timescale 1ns/1ps
`default_nettype none
module isftc_chk (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_serial_clock_pin,
    input wire logic i_serial_line_pin,
    input wire logic o_serial_line_pin,
    input wire logic o_serial_line_oe,
    input wire logic o_frame_sync,
    input wire logic o_line_valid,
    input wire logic [9:0] o_col_addr,
    input wire logic [8:0] o_row_addr,
    input wire logic o_cfa_red_line
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);
    // ==========
    // colour and row at the last valid row start
    logic seen;
    logic last_cfa;
    logic [8:0] last_row;
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            seen <= 1'b0;
        end else if ($rose(o_line_valid)) begin
            seen <= 1'b1;
            last_cfa <= o_cfa_red_line;
            last_row <= o_row_addr;
        end
    end
    // ==========
    // serial slave
    a_pin_low: assert property (o_serial_line_pin == 1'b0)
        else $error("data pin not low");
    a_oe_low_clk: assert property ($changed(o_serial_line_oe) |-> !i_serial_clock_pin)
        else $error("data line moved while clock high");
    a_ack_held: assert property ($rose(o_serial_line_oe) |-> o_serial_line_oe [*8])
        else $error("data line pull too short");
    // ==========
    // frame and line timing
    a_valid_sync: assert property (o_line_valid |-> o_frame_sync)
        else $error("valid line outside frame sync");
    a_sync_lead: assert property ($rose(o_frame_sync) |-> !o_line_valid [*8])
        else $error("valid line at frame start");
    a_row_tail: assert property ($fell(o_line_valid) |-> !o_line_valid [*4])
        else $error("row tail shorter than four");
    a_cfa_swap: assert property ($rose(o_line_valid) && seen &&
        (o_row_addr == last_row + 9'h001 || o_row_addr + 9'h001 == last_row)
        |-> o_cfa_red_line != last_cfa) else $error("colour line did not alternate");
    a_reset_quiet: assert property ($rose(i_nrst) |-> !o_serial_line_oe &&
        !o_frame_sync && !o_line_valid && o_row_addr == 9'h000)
        else $error("outputs active after reset");
endmodule
bind isftc_top isftc_chk i_chk (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_serial_clock_pin(i_serial_clock_pin), .i_serial_line_pin(i_serial_line_pin),
    .o_serial_line_pin(o_serial_line_pin), .o_serial_line_oe(o_serial_line_oe),
    .o_frame_sync(o_frame_sync), .o_line_valid(o_line_valid), .o_col_addr(o_col_addr),
    .o_row_addr(o_row_addr), .o_cfa_red_line(o_cfa_red_line));
`default_nettype wire

// ### tb/tb.sv
// Purpose: self-checking bench of serial slave and frame timing
// Assumes: host model drives the serial pins
// Notes: a 16x16 window keeps frames short
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ==========
    // pins and tallies
    localparam int ROW = 26; // hblank 4 + hold 2 + width 16 + tail 4
    logic i_mclk, i_nrst, scl, host_low, sda_pin, sda_oe, fs, lv, cfa, fs_q, lv_q;
    logic [9:0] col, c0;
    logic [8:0] row, r0;
    wire sda;
    int err_count = 0;
    int n_checks = 0;
    int cyc, f_cnt, f_len, p_cnt, f_pix, h_cnt, f_hi;
    logic [7:0] wq[$], rq[$], ex[$];
    isftc_top #(.CHIP_ID(8'h3c)) i_dut ( // identity value is arbitrary
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_serial_clock_pin(scl), .i_serial_line_pin(sda),
        .o_serial_line_pin(sda_pin), .o_serial_line_oe(sda_oe), .o_frame_sync(fs),
        .o_line_valid(lv), .o_col_addr(col), .o_row_addr(row), .o_cfa_red_line(cfa));
    isftc_host i_host (.i_mclk(i_mclk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
    // pulled-up wire: either side pulls low
    assign sda = ~host_low & (~sda_oe | sda_pin);
    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    // per-frame counts, closed at each sync rise; hang limit
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        fs_q <= fs;
        lv_q <= lv;
        if (lv && !lv_q) c0 <= col;
        if (lv && !lv_q && p_cnt == 0) r0 <= row;
        if (fs && !fs_q) begin
            f_len <= f_cnt;
            f_pix <= p_cnt;
            f_hi <= h_cnt;
            f_cnt <= 1;
            p_cnt <= 0;
            h_cnt <= 1;
        end else begin
            f_cnt <= f_cnt + 1;
            p_cnt <= p_cnt + lv;
            h_cnt <= h_cnt + fs;
        end
        if (cyc == 60000) begin
            err_count++;
            stop_test();
        end
    end
    // ==========
    // shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a); // wq from register a on
        logic k;
        i_host.start();
        i_host.send(8'h42, k);
        chk("ack write address", 1, k);
        i_host.send(a, k);
        chk("ack register", 1, k);
        foreach (wq[i]) begin
            i_host.send(wq[i], k);
            chk("ack data", 1, k);
        end
        i_host.stop();
    endtask
    task automatic rd(input logic [7:0] a, input int n); // n bytes from a into rq
        logic k;
        logic [7:0] d;
        rq = {};
        i_host.start();
        i_host.send(8'h42, k);
        i_host.send(a, k);
        i_host.start();
        i_host.send(8'h43, k);
        chk("ack read address", 1, k);
        for (int i = 0; i < n; i++) begin
            i_host.recv(i < n - 1, d);
            rq.push_back(d);
        end
        i_host.stop();
    endtask
    task automatic stop_test();
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ==========
    // scenarios
    task automatic t_defaults(); // slots 0x00..0x12 after reset
        logic [7:0] dflt[19] = '{8'h3c, 8'h6a, 8'h70, 8'h00, 8'h96, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h01, 8'he8, 8'h02, 8'h88, 8'h02, 8'h04, 8'h00, 8'h00, 8'h00, 8'h42};
        rd(8'h00, 19);
        foreach (dflt[i]) chk("reset value", dflt[i], rq[i]);
    endtask
    task automatic t_bad_addr(); // foreign address goes unanswered
        logic k;
        i_host.start();
        i_host.send(8'h44, k);
        chk("ack foreign address", 0, k);
        i_host.stop();
    endtask
    task automatic t_config(); // small window, read back
        wq = {8'h04, 8'h08, 8'h00, 8'h10};
        wr(8'h01);
        wq = {8'h00, 8'h10, 8'h00, 8'h10, 8'h02, 8'h02, 8'h00};
        ex = wq;
        wr(8'h09);
        wq = {8'h02};
        wr(8'h12);
        rd(8'h09, 7);
        foreach (ex[i]) chk("burst read", ex[i], rq[i]);
        rd(8'h12, 1);
        chk("single read", 8'h02, rq[0]);
    endtask
    task automatic t_frame(input int rows, input int cx, input int rx); // one settled frame
        repeat (2) @(posedge fs);
        repeat (2) @(negedge i_mclk);
        chk("frame cycles", rows * ROW, f_len);
        chk("sync cycles", 20 * ROW, f_hi);
        chk("valid pixels", 8 * 16, f_pix);
        chk("first column", cx, c0);
        chk("first row", rx, r0);
    endtask
    task automatic t_expo(); // exposure at and past height plus blanking
        logic [7:0] ev[3] = '{8'h18, 8'h19, 8'h40};
        int fr[3] = '{24, 25, 64};
        foreach (ev[i]) begin
            wq = {ev[i]};
            wr(8'h04);
            t_frame(fr[i], 15, 11);
        end
    endtask
    initial begin
        i_nrst = 1'b0;
        repeat (20) @(negedge i_mclk);
        i_nrst = 1'b1;
        repeat (4) @(negedge i_mclk);
        t_defaults();
        t_bad_addr();
        t_config();
        t_frame(24, 0, 4);
        wq = {8'h03};
        wr(8'h14);
        t_frame(24, 15, 11);
        t_expo();
        stop_test();
    end
endmodule
`default_nettype wire
